// >>> bench/overlimit_critical_limit_regs_bench.sv
`timescale 1ns/1ps
module overlimit_critical_limit_regs_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] power_result = 16'h0000;
  logic [15:0] bus_result = 16'h0000;
  logic [15:0] shunt_mv = 16'h0000;
  logic        limit_output_enable = 1'b0;
  logic        latch_clear = 1'b0;
  logic        warning_in = 1'b0;
  logic        gp_ext = 1'b1;
  wire         gp_pin_in;
  logic        gp_pin_out;
  logic        gp_pin_oe_n;
  logic        pw_f;
  logic        hi_f;
  logic        lo_f;
  logic        limit_out;
  logic        crit_oe_n;
  logic        warning_out;
  logic        critical_raw;
  logic        rd_v;
  logic [15:0] rd_val;
  logic [15:0] obs = 16'h0000;
  logic        obs_v = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] d;
  logic [15:0] p;
  logic [15:0] n;
  logic [12:0] v;
  int          err_count = 0;
  int          num_checks = 0;

  always #5 clk = ~clk;
  // Pin level: driven by the block or held by the outside pull
  assign gp_pin_in = gp_pin_oe_n ? gp_ext : gp_pin_out;

  overlimit_critical_limit_regs #(.delay_step_cyc(4))
    overlimit_critical_limit_regs_inst (
    .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .power_result(power_result), .bus_result(bus_result),
    .shunt_mv(shunt_mv), .limit_output_enable(limit_output_enable),
    .latch_clear(latch_clear), .warning_in(warning_in),
    .gp_pin_in(gp_pin_in), .gp_pin_out(gp_pin_out),
    .gp_pin_oe_n(gp_pin_oe_n), .power_exceed_flag(pw_f),
    .bus_high_exceed_flag(hi_f), .bus_low_exceed_flag(lo_f),
    .limit_out(limit_out), .critical_out_oe_n(crit_oe_n),
    .warning_out(warning_out), .critical_raw(critical_raw));

  reg_host reg_host_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rd_v(rd_v), .rd_val(rd_val));

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got);
    logic [15:0] e;
    e = exp_q.pop_front();
    num_checks++;
    if (got !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, e);
    end
  endtask

  // ****************************************************************
  // Result watcher
  // ****************************************************************
  always @(posedge clk)
  begin
    if (rd_v)
      cmp(rd_val);
    if (obs_v)
      cmp(obs);
  end

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    reg_host_inst.rd(a);
  endtask

  task automatic pchk(input logic [15:0] got, input logic [15:0] e);
    exp_q.push_back(e);
    obs = got;
    obs_v = 1'b1;
    @(posedge clk);
    #1;
    obs_v = 1'b0;
  endtask

  task automatic wait_n(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic crit(input logic [15:0] s, input logic [1:0] e);
    shunt_mv = s;
    wait_n(4);
    pchk({14'h0, critical_raw, crit_oe_n}, {14'h0, e});
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    void'($urandom(32'h2650));
    wait_n(5);
    rst_n = 1'b1;
    for (int a = 8'h11; a <= 8'h16; a++)
      rchk(a[7:0], (a == 8'h14) ? 16'h0080 : 16'h0000);
    for (int a = 8'h11; a <= 8'h15; a++)
    begin
      d = 16'($urandom());
      reg_host_inst.wr(a[7:0], d);
      wait_n(2);
      if (a == 8'h14)
        d[7] = d[6] ? d[5] : gp_ext;
      rchk(a[7:0], d);
      reg_host_inst.wr(a[7:0], 16'h0000);
    end
    d = 16'($urandom_range(16'hfff0, 1));
    reg_host_inst.wr(8'h11, d);
    limit_output_enable = 1'b1;
    power_result = d + 16'h0001;
    wait_n(3);
    pchk({14'h0, pw_f, limit_out}, 16'h0002);
    power_result = d;
    wait_n(3);
    pchk({14'h0, pw_f, limit_out}, 16'h0001);
    v = 13'($urandom_range(8190, 1));
    reg_host_inst.wr(8'h12, {v, 3'b010});
    bus_result = {v, 3'b111};
    wait_n(3);
    pchk({14'h0, hi_f, limit_out}, 16'h0000);
    bus_result = {v + 13'h0001, 3'b000};
    wait_n(3);
    pchk({14'h0, hi_f, limit_out}, 16'h0003);
    limit_output_enable = 1'b0;
    wait_n(3);
    pchk({14'h0, hi_f, limit_out}, 16'h0002);
    limit_output_enable = 1'b1;
    reg_host_inst.wr(8'h12, 16'hfff9);
    reg_host_inst.wr(8'h13, {v, 3'b000});
    bus_result = {v, 3'b000};
    wait_n(3);
    pchk({14'h0, lo_f, limit_out}, 16'h0001);
    bus_result = {v - 13'h0001, 3'b111};
    wait_n(3);
    pchk({14'h0, lo_f, limit_out}, 16'h0002);
    bus_result = {v, 3'b000};
    wait_n(3);
    pchk({14'h0, lo_f, limit_out}, 16'h0000);
    latch_clear = 1'b1;
    wait_n(1);
    latch_clear = 1'b0;
    wait_n(3);
    pchk({14'h0, lo_f, limit_out}, 16'h0001);
    for (int m = 0; m < 4; m++)
    begin
      reg_host_inst.wr(8'h14, {9'h0, m[1:0], 5'h0});
      wait_n(3);
      pchk({14'h0, gp_pin_oe_n, m[1] & gp_pin_out},
           {14'h0, ~m[1], m[1] & m[0]});
    end
    p = 16'($urandom_range(235, 20));
    n = 16'($urandom_range(200, 1));
    reg_host_inst.wr(8'h15, {n[7:0], 8'h00});
    reg_host_inst.wr(8'h14, {p[7:0], 8'h00});
    crit(p + 16'h0001, 2'b10);
    crit(p, 2'b01);
    crit(-(n + 16'h0001), 2'b10);
    crit(-n, 2'b01);
    reg_host_inst.wr(8'h14, {p[7:0], 8'h10});
    crit(p, 2'b00);
    crit(p + 16'h0001, 2'b11);
    reg_host_inst.wr(8'h14, {p[7:0], 8'h0e});
    crit(p + 16'h0001, 2'b10);
    crit(p - 16'd13, 2'b10);
    crit(p - 16'd15, 2'b01);
    reg_host_inst.wr(8'h14, {p[7:0], 8'h01});
    crit(p + 16'h0001, 2'b10);
    crit(16'h0000, 2'b00);
    latch_clear = 1'b1;
    wait_n(1);
    latch_clear = 1'b0;
    crit(16'h0000, 2'b01);
    reg_host_inst.wr(8'h14, {p[7:0], 8'h00});
    reg_host_inst.wr(8'h15, {n[7:0], 8'h10});
    shunt_mv = p + 16'h0001;
    wait_n(6300);
    pchk({15'h0, crit_oe_n}, 16'h0001);
    wait_n(200);
    pchk({15'h0, crit_oe_n}, 16'h0000);
    shunt_mv = 16'h0000;
    reg_host_inst.wr(8'h15, {n[7:0], 8'h02});
    warning_in = 1'b1;
    wait_n(4);
    pchk({15'h0, warning_out}, 16'h0000);
    wait_n(10);
    pchk({15'h0, warning_out}, 16'h0001);
    warning_in = 1'b0;
    reg_host_inst.wr(8'h15, {n[7:0], 8'h00});
    warning_in = 1'b1;
    wait_n(2);
    pchk({15'h0, warning_out}, 16'h0001);
    wait_n(2);
    give_verdict();
  end
endmodule

// >>> bench/reg_host.sv
`timescale 1ns/1ps
// ****************************************************************
// Host model: register writes and reads
// ****************************************************************
module reg_host
(
  input  wire logic        clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata,
  output logic             rd_v,
  output logic      [15:0] rd_val
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    rd_v = 1'b0;
    rd_val = 16'h0000;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    // Stale data is scrambled so nothing relies on it
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    @(posedge clk);
    #1;
    rd_val = reg_rdata;
    rd_v = 1'b1;
    @(posedge clk);
    #1;
    rd_v = 1'b0;
  endtask
endmodule

// >>> logic/limit_pkg.sv
package limit_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] power_limit_addr   = 8'h11;
  localparam logic [7:0] bus_high_addr      = 8'h12;
  localparam logic [7:0] bus_low_addr       = 8'h13;
  localparam logic [7:0] crit_pos_addr      = 8'h14;
  localparam logic [7:0] crit_neg_addr      = 8'h15;
  localparam logic [2:0] first_index        = 3'h1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] reg_reset_value   = 16'h0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int limit_lsb        = 3;
  localparam int polarity_bit     = 1;
  localparam int latch_bit        = 0;
  localparam int threshold_lsb    = 8;
  localparam int gp_readback_bit  = 7;
  localparam int gp_mode_lsb      = 5;
  localparam int crit_pol_bit     = 4;
  localparam int hyst_lsb         = 1;
  localparam int filter_lsb       = 4;
  localparam int delay_lsb        = 0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int clk_period_ns    = 10;
  localparam int filter_step_ns   = 64000;
  localparam int filter_step_cyc  = filter_step_ns / clk_period_ns;
  localparam int delay_step_ms    = 100;
  localparam int delay_step_cyc   = delay_step_ms * 1000000 / clk_period_ns;

endpackage

// >>> logic/limit_regfile.sv
`timescale 1ns/1ps
// ****************************************************************
// Five-entry 16-bit register store with registered read data
// ****************************************************************
module limit_regfile
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_idx,
  input  wire logic [15:0] wr_data,
  input  wire logic [2:0]  rd_idx,
  output logic      [15:0] rd_data,
  output logic      [79:0] all_q
);

  genvar i;
  generate
    for (i = 0; i < 5; i++)
    begin : g_entry
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          all_q[i*16 +: 16] <= limit_pkg::reg_reset_value;
        else if (wr_en && wr_idx == 3'(i))
          all_q[i*16 +: 16] <= wr_data;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 16'h0000;
    else if (rd_idx < 3'h5)
      rd_data <= all_q[rd_idx*16 +: 16];
    else
      rd_data <= 16'h0000;
  end

endmodule

// >>> logic/overlimit_critical_limit_regs.sv
`timescale 1ns/1ps
// Contract
// R01: Power above the power limit sets its flag and the enabled output.
// R02: Bus voltage above bits 15..3 of the high limit sets its flag.
// R03: Bus voltage below bits 15..3 of the low limit sets its flag.
// R04: Bit 1 of the high-limit register makes the output assert high.
// R05: Bit 0 of the high-limit register latches the over-limit output.
// R06: Critical positive threshold is an unsigned byte in bits 15..8.
// R07: Bit 7 of the positive critical register reads the pin level.
// R08: Pin mode 0x/1x: 00,01 release, 10 drive low, 11 drive high.
// R09: Bit 4 of the positive critical register sets critical polarity.
// R10: Hysteresis bits 3..1 give code times 2 mV of hysteresis.
// R11: Bit 0 of the positive critical register latches critical output.
// R12: Negative threshold magnitude sits in bits 15..8, negative only.
// R13: Filter bits 7..4 give code times 0.064 ms of output filtering.
// R14: Warning delay bits 3..0 give code times 0.1 s, default 0.
// R15: A latched output holds until the clear input is pulsed.
module overlimit_critical_limit_regs
#(
  parameter int delay_step_cyc = limit_pkg::delay_step_cyc
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic [15:0] power_result,
  input  wire logic [15:0] bus_result,
  input  wire logic [15:0] shunt_mv,
  input  wire logic        limit_output_enable,
  input  wire logic        latch_clear,
  input  wire logic        warning_in,
  input  wire logic        gp_pin_in,
  output logic             gp_pin_out,
  output logic             gp_pin_oe_n,
  output logic             power_exceed_flag,
  output logic             bus_high_exceed_flag,
  output logic             bus_low_exceed_flag,
  output logic             limit_out,
  output logic             critical_out_oe_n,
  output logic             warning_out,
  output logic             critical_raw
);

  // ****************************************************************
  // Register store
  // ****************************************************************
  logic [79:0] regs;
  logic [15:0] store_rdata;
  logic [2:0]  wr_idx;
  logic [2:0]  rd_idx;
  logic        wr_hit;
  logic        gp_q;
  logic        rd_pos_q;
  logic        rd_hit_q;

  always_comb
  begin
    if (reg_addr >= limit_pkg::power_limit_addr &&
        reg_addr <= limit_pkg::crit_neg_addr)
    begin
      wr_hit = 1'b1;
      wr_idx = 3'(reg_addr - limit_pkg::power_limit_addr);
    end
    else
    begin
      wr_hit = 1'b0;
      wr_idx = 3'h7;
    end
  end

  assign rd_idx = wr_idx;

  limit_regfile u_store
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (reg_wr && wr_hit),
    .wr_idx  (wr_idx),
    .wr_data (reg_wdata),
    .rd_idx  (rd_idx),
    .rd_data (store_rdata),
    .all_q   (regs)
  );

  logic [15:0] power_limit_value;
  logic [15:0] high_reg;
  logic [15:0] low_reg;
  logic [15:0] pos_reg;
  logic [15:0] neg_reg;
  logic [12:0] bus_high_limit_value;
  logic [12:0] bus_low_limit_value;
  logic        limit_polarity;
  logic        limit_output_latch;
  logic [7:0]  critical_threshold;
  logic [7:0]  critical_neg_threshold;
  logic [1:0]  gp_pin_mode;
  logic        critical_output_polarity;
  logic [2:0]  critical_hysteresis;
  logic        critical_output_latch;
  logic [3:0]  critical_filter_time;
  logic [3:0]  warning_delay;

  assign power_limit_value = regs[15:0];
  assign high_reg          = regs[31:16];
  assign low_reg           = regs[47:32];
  assign pos_reg           = regs[63:48];
  assign neg_reg           = regs[79:64];
  assign bus_high_limit_value = high_reg[15:limit_pkg::limit_lsb];
  assign bus_low_limit_value  = low_reg[15:limit_pkg::limit_lsb];
  assign limit_polarity       = high_reg[limit_pkg::polarity_bit];
  assign limit_output_latch   = high_reg[limit_pkg::latch_bit];
  assign critical_threshold   = pos_reg[15:limit_pkg::threshold_lsb];
  assign gp_pin_mode = pos_reg[limit_pkg::gp_mode_lsb +: 2];
  assign critical_output_polarity = pos_reg[limit_pkg::crit_pol_bit];
  assign critical_hysteresis = pos_reg[limit_pkg::hyst_lsb +: 3];
  assign critical_output_latch = pos_reg[limit_pkg::latch_bit];
  assign critical_neg_threshold = neg_reg[15:limit_pkg::threshold_lsb];
  assign critical_filter_time = neg_reg[limit_pkg::filter_lsb +: 4];
  assign warning_delay        = neg_reg[limit_pkg::delay_lsb +: 4];

  // ****************************************************************
  // Read path with pin readback
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_pos_q <= 1'b0;
      rd_hit_q <= 1'b0;
      gp_q     <= 1'b0;
    end
    else
    begin
      rd_pos_q <= reg_addr == limit_pkg::crit_pos_addr;
      rd_hit_q <= reg_rd && wr_hit;
      gp_q     <= gp_pin_in;
    end
  end

  // Read data stands one cycle, two cycles after the read strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (!rd_hit_q)
      reg_rdata <= 16'h0000;
    else if (rd_pos_q)
      reg_rdata <= {store_rdata[15:8], gp_q, store_rdata[6:0]}; // see R07
    else
      reg_rdata <= store_rdata;
  end

  // ****************************************************************
  // Over-limit comparisons
  // ****************************************************************
  logic pwr_over;
  logic bus_over;
  logic bus_under;
  logic any_over;

  assign pwr_over  = power_result > power_limit_value; // see R01
  assign bus_over  = bus_result[15:3] > bus_high_limit_value; // see R02
  assign bus_under = bus_result[15:3] < bus_low_limit_value; // see R03
  assign any_over  = pwr_over || bus_over || bus_under;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_exceed_flag    <= 1'b0;
      bus_high_exceed_flag <= 1'b0;
      bus_low_exceed_flag  <= 1'b0;
    end
    else
    begin
      power_exceed_flag    <= pwr_over; // see R01
      bus_high_exceed_flag <= bus_over; // see R02
      bus_low_exceed_flag  <= bus_under; // see R03
    end
  end

  logic limit_hold_q;
  logic limit_active;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      limit_hold_q <= 1'b0;
    else if (any_over && limit_output_enable && limit_output_latch)
      limit_hold_q <= 1'b1; // see R05, R15
    else if (latch_clear || !limit_output_latch)
      limit_hold_q <= 1'b0;
  end

  assign limit_active = limit_output_enable && any_over || limit_hold_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      limit_out <= 1'b1;
    else
      limit_out <= limit_polarity ? limit_active : !limit_active; // see R04
  end

  // ****************************************************************
  // Critical comparator with hysteresis, filter and latch
  // ****************************************************************
  logic [8:0]  hyst_mv;
  logic [15:0] mag;
  logic        neg_sign;
  logic        crit_q;
  logic        crit_cmp;
  logic [8:0]  pos_rel;
  logic [8:0]  neg_rel;

  assign neg_sign = shunt_mv[15];
  assign mag      = neg_sign ? 16'(-shunt_mv) : shunt_mv;
  assign hyst_mv  = {5'h0, critical_hysteresis, 1'b0}; // see R10
  assign pos_rel  = {1'b0, critical_threshold} - hyst_mv;
  assign neg_rel  = {1'b0, critical_neg_threshold} - hyst_mv;

  always_comb
  begin
    if (!neg_sign)
    begin
      if (crit_q && pos_rel[8] == 1'b0)
        crit_cmp = mag > 16'(pos_rel); // see R06, R10
      else
        crit_cmp = mag > 16'(critical_threshold); // see R06
    end
    else
    begin
      if (crit_q && neg_rel[8] == 1'b0)
        crit_cmp = mag > 16'(neg_rel); // see R12, R10
      else
        crit_cmp = mag > 16'(critical_neg_threshold); // see R12
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      crit_q <= 1'b0;
    else
      crit_q <= crit_cmp;
  end

  logic [16:0] filt_cnt_q;
  logic [16:0] filt_target;
  logic        crit_filt_q;

  assign filt_target = 17'(critical_filter_time * limit_pkg::filter_step_cyc);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filt_cnt_q  <= 17'h00000;
      crit_filt_q <= 1'b0;
    end
    else if (crit_q == crit_filt_q)
      filt_cnt_q <= 17'h00000;
    else if (filt_cnt_q >= filt_target)
    begin
      crit_filt_q <= crit_q; // see R13
      filt_cnt_q  <= 17'h00000;
    end
    else
      filt_cnt_q <= filt_cnt_q + 17'h00001;
  end

  logic crit_hold_q;
  logic crit_active;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      crit_hold_q <= 1'b0;
    else if (crit_filt_q && critical_output_latch)
      crit_hold_q <= 1'b1; // see R11, R15
    else if (latch_clear || !critical_output_latch)
      crit_hold_q <= 1'b0;
  end

  assign crit_active = crit_filt_q || crit_hold_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      critical_out_oe_n <= 1'b1;
      critical_raw      <= 1'b0;
    end
    else
    begin
      // Open drain: enable pulls low when the pin should read low
      critical_out_oe_n <= critical_output_polarity ? crit_active
                                                    : !crit_active; // see R09
      critical_raw      <= crit_q;
    end
  end

  // ****************************************************************
  // General-purpose pin
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gp_pin_oe_n <= 1'b1;
      gp_pin_out  <= 1'b0;
    end
    else
    begin
      gp_pin_oe_n <= !gp_pin_mode[1]; // see R08
      gp_pin_out  <= gp_pin_mode[0]; // see R08
    end
  end

  // ****************************************************************
  // Warning output delay
  // ****************************************************************
  logic [31:0] step_cnt_q;
  logic [3:0]  steps_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      step_cnt_q  <= 32'h0;
      steps_q     <= 4'h0;
      warning_out <= 1'b0;
    end
    else if (!warning_in)
    begin
      step_cnt_q  <= 32'h0;
      steps_q     <= 4'h0;
      warning_out <= 1'b0;
    end
    else if (steps_q >= warning_delay)
      warning_out <= 1'b1; // see R14
    else if (step_cnt_q == 32'(delay_step_cyc - 1))
    begin
      step_cnt_q <= 32'h0;
      steps_q    <= steps_q + 4'h1;
    end
    else
      step_cnt_q <= step_cnt_q + 32'h1;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence over_seen;
    power_result > power_limit_value && limit_output_enable;
  endsequence

  power_flag_a: assert property ( // see R01
    @(posedge clk) disable iff (!rst_n)
    (power_result > power_limit_value) |=> power_exceed_flag)
    else $error("power flag not set");

  bus_high_a: assert property ( // see R02
    @(posedge clk) disable iff (!rst_n)
    (bus_result[15:3] > high_reg[15:3]) |=> bus_high_exceed_flag)
    else $error("bus high flag not set");

  bus_low_a: assert property ( // see R03
    @(posedge clk) disable iff (!rst_n)
    (bus_result[15:3] < low_reg[15:3]) |=> bus_low_exceed_flag)
    else $error("bus low flag not set");

  limit_pol_a: assert property ( // see R04
    @(posedge clk) disable iff (!rst_n)
    over_seen |=> (limit_out == $past(high_reg[1])))
    else $error("over-limit polarity wrong");

  limit_latch_a: assert property ( // see R05
    @(posedge clk) disable iff (!rst_n)
    (over_seen and high_reg[0] && !latch_clear) ##1
    (high_reg[0] && !latch_clear) |=> limit_out == $past(high_reg[1]))
    else $error("over-limit latch lost");

  gp_drive_a: assert property ( // see R08
    @(posedge clk) disable iff (!rst_n)
    gp_pin_mode == 2'b10 |=> !gp_pin_oe_n && !gp_pin_out)
    else $error("pin mode 10 not driving low");

  gp_read_a: assert property ( // see R07
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == limit_pkg::crit_pos_addr
    |=> ##1 reg_rdata[limit_pkg::gp_readback_bit] == $past(gp_pin_in, 2))
    else $error("pin readback wrong");

  warn_zero_a: assert property ( // see R14
    @(posedge clk) disable iff (!rst_n)
    warning_in && warning_delay == 4'h0 ##1 warning_in
    |=> warning_out)
    else $error("warning not passed with zero delay");

endmodule
